// File: design/sfq_pkg.sv
// Package for the serial queue control and receive port block.
// Assumes one system clock, synchronous active-low reset, and Avalon-MM access.
`default_nettype none

package sfq_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_CTRL_SET = 16'h100C;
    localparam logic [15:0] ADDR_CTRL_CLEAR = 16'h1010;
    localparam logic [15:0] ADDR_RX_DATA = 16'h1014;
    localparam logic [15:0] ADDR_RX_DATA_STATUS = 16'h1018;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'h1040;
    localparam logic [15:0] ADDR_IRQ_CLEAR = 16'h1044;
    localparam logic [15:0] ADDR_IRQ_ENABLE = 16'h1048;
    localparam logic [15:0] ADDR_QUEUE_CFG = 16'h104C;
    localparam logic [15:0] ADDR_QUEUE_LEVEL = 16'h1050;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_RX_LEVEL_EN = 0;
    localparam int BIT_TX_LEVEL_EN = 1;
    localparam int BIT_RX_TIMEOUT_EN = 4;
    localparam int BIT_RX_FLUSH = 8;
    localparam int BIT_TX_FLUSH = 9;
    localparam int BIT_FRAME_ERR = 13;
    localparam int BIT_PARITY_ERR = 14;
    localparam int BIT_NOISE = 15;

    // Sticky event bits of the interrupt status register.
    localparam int EV_RX_LEVEL = 0;
    localparam int EV_TX_LEVEL = 1;
    localparam int EV_RX_TIMEOUT = 2;
    localparam int EV_RX_OVERRUN = 3;
    localparam int EV_WIDTH = 4;

    // ------------------------------------------------------------------
    // Sizes, reset values and timing
    // ------------------------------------------------------------------
    localparam int CHAR_WIDTH = 9;
    localparam int RX_DEPTH = 8;
    localparam int RX_PTR_W = 3;
    localparam int RX_CNT_W = 4;
    localparam int TX_DEPTH = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int TIMEOUT_US = 10;
    localparam int CLOCK_MHZ = 100;
    localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLOCK_MHZ;
    localparam int TIMER_W = 10;

    // One received character and its line status.
    typedef struct packed {
        logic line_noise_flag;
        logic parity_fault_flag;
        logic stop_bit_missing_flag;
        logic [CHAR_WIDTH-1:0] received_character;
    } sfq_rx_entry_s;

    // Control bits held for the channel.
    typedef struct packed {
        logic rx_timeout_irq_enable;
        logic tx_level_irq_enable;
        logic rx_level_irq_enable;
    } sfq_ctrl_s;

endpackage

`default_nettype wire

// File: design/sfq_rx_queue.sv
// Receive queue of characters with status for one serial channel.
// Assumes a single-cycle push from the serial receiver and pop from the bus side.
`default_nettype none

module sfq_rx_queue
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Push side
    input wire logic i_push,
    input wire sfq_pkg::sfq_rx_entry_s i_push_data,
    output logic o_push_ready,
    // Pop side
    input wire logic i_pop,
    output sfq_pkg::sfq_rx_entry_s o_head,
    // Control and state
    input wire logic i_flush,
    output logic [sfq_pkg::RX_CNT_W-1:0] o_count
);

    sfq_pkg::sfq_rx_entry_s mem [sfq_pkg::RX_DEPTH];
    logic [sfq_pkg::RX_PTR_W-1:0] wr_ptr;
    logic [sfq_pkg::RX_PTR_W-1:0] rd_ptr;
    logic [sfq_pkg::RX_CNT_W-1:0] count;
    logic [sfq_pkg::RX_PTR_W-1:0] next_wr_ptr;
    logic [sfq_pkg::RX_PTR_W-1:0] next_rd_ptr;
    logic [sfq_pkg::RX_CNT_W-1:0] next_count;
    logic do_push;
    logic do_pop;

    assign o_push_ready = (count != sfq_pkg::RX_CNT_W'(sfq_pkg::RX_DEPTH));
    assign do_push = i_push && o_push_ready && !i_flush;
    assign do_pop = i_pop && (count != '0) && !i_flush;
    assign o_count = count;
    assign o_head = (count != '0) ? mem[rd_ptr] : '0;

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (i_flush)
        begin
            // Flush empties the queue by aligning the pointers.
            next_rd_ptr = wr_ptr;
            next_count = '0;
        end
        else
        begin
            if (do_push)
            begin
                next_wr_ptr = wr_ptr + 1'b1;
            end
            if (do_pop)
            begin
                next_rd_ptr = rd_ptr + 1'b1;
            end
            if (do_push && !do_pop)
            begin
                next_count = count + 1'b1;
            end
            else if (do_pop && !do_push)
            begin
                next_count = count - 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= i_push_data;
        end
    end

endmodule

`default_nettype wire

// File: design/sfq_rx_timeout.sv
// Receive timeout timer for one channel.
// Assumes the restart and enable come from the control logic on the same clock.
`default_nettype none

module sfq_rx_timeout
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Control
    input wire logic i_enable,
    input wire logic i_restart,
    input wire logic i_not_empty,
    // Event
    output logic o_expired
);

    logic [sfq_pkg::TIMER_W-1:0] count;
    logic [sfq_pkg::TIMER_W-1:0] next_count;
    logic fired;
    logic next_fired;

    localparam logic [sfq_pkg::TIMER_W-1:0] LAST =
        sfq_pkg::TIMER_W'(sfq_pkg::TIMEOUT_CYCLES - 1);

    always_comb
    begin
        next_count = count;
        next_fired = fired;
        o_expired = 1'b0;
        if (!i_enable || i_restart || !i_not_empty)
        begin
            // The count clears to zero while disabled or while the queue is empty, and starts over on a restart.
            next_count = '0;
            next_fired = 1'b0;
        end
        else if (!fired)
        begin
            if (count == LAST)
            begin
                o_expired = 1'b1;
                next_fired = 1'b1;
            end
            else
            begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            count <= '0;
            fired <= 1'b0;
        end
        else
        begin
            count <= next_count;
            fired <= next_fired;
        end
    end

endmodule

`default_nettype wire

// File: design/sfq_uart_port.sv
// Control and receive-data access for one serial channel of the shared system queue.
// Assumes an Avalon-MM master on the same clock and a receiver pushing one entry a cycle.
//
// Contract
// - Level interrupt enables at bits 0, 1, reset clear.
// - Timeout enable bit 4 also enables counting.
// - Writing one to bit 4 restarts timeout.
// - Set bit 8 empties receive queue.
// - Set bit 9 empties transmit queue.
// - Clear register ones disable bits 0, 1, 4.
// - Zeros written to clear change nothing.
// - Plain data read gives oldest character 8:0.
// - Status read gives character plus error flags.
// - Bit 13 flags a missing stop bit.
// - Bit 14 parity error, bit 15 noise.
// - Set register ones set; read returns enables.
//
// Register access over Avalon-MM was decided locally.
`default_nettype none

module sfq_uart_port
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Avalon-MM slave
    input wire logic [15:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Receiver push side
    input wire logic i_rx_push,
    input wire sfq_pkg::sfq_rx_entry_s i_rx_entry,
    output logic o_rx_push_ready,
    // Transmit queue flush towards the transmit path
    output logic o_tx_queue_flush,
    // Interrupt
    output logic o_irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    sfq_pkg::sfq_ctrl_s ctrl;
    sfq_pkg::sfq_ctrl_s next_ctrl;
    logic [7:0] rx_threshold;
    logic [7:0] next_rx_threshold;
    logic [sfq_pkg::EV_WIDTH-1:0] irq_status;
    logic [sfq_pkg::EV_WIDTH-1:0] next_irq_status;
    logic [sfq_pkg::EV_WIDTH-1:0] irq_enable;
    logic [sfq_pkg::EV_WIDTH-1:0] next_irq_enable;
    logic [31:0] readdata;
    logic [31:0] next_readdata;
    logic answered;
    logic next_answered;
    logic rx_flush;
    logic next_rx_flush;
    logic tx_flush;
    logic next_tx_flush;
    logic timeout_restart;
    logic next_timeout_restart;
    logic rx_pop;
    logic [sfq_pkg::RX_CNT_W-1:0] rx_count;
    sfq_pkg::sfq_rx_entry_s rx_head;
    logic timeout_expired;
    logic rx_level_hit;
    logic rx_level_prev;
    logic overrun;
    logic [31:0] wmask;
    logic wr_access;
    logic rd_access;

    // Byte enables expand to a bit mask for every write.
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    function automatic logic [31:0] entry_word(input sfq_pkg::sfq_rx_entry_s e, input logic st);
        logic [31:0] w;
        w = '0;
        w[sfq_pkg::CHAR_WIDTH-1:0] = e.received_character;
        if (st)
        begin
            w[sfq_pkg::BIT_FRAME_ERR] = e.stop_bit_missing_flag;
            w[sfq_pkg::BIT_PARITY_ERR] = e.parity_fault_flag;
            w[sfq_pkg::BIT_NOISE] = e.line_noise_flag;
        end
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // Every access waits one cycle, so a read pops exactly once.
    assign o_waitrequest = (i_read || i_write) && !answered;
    assign wr_access = i_write && !answered;
    assign rd_access = i_read && !answered;
    assign wmask = lane_mask(i_byteenable);
    assign o_readdata = readdata;
    assign o_tx_queue_flush = tx_flush;
    assign o_irq = |(irq_status & irq_enable);
    assign rx_level_hit = ({4'h0, rx_count} > rx_threshold);
    assign overrun = i_rx_push && !o_rx_push_ready;
    assign rx_pop = rd_access && ((i_address == sfq_pkg::ADDR_RX_DATA) ||
                                  (i_address == sfq_pkg::ADDR_RX_DATA_STATUS));

    always_comb
    begin
        next_ctrl = ctrl;
        next_rx_threshold = rx_threshold;
        next_irq_enable = irq_enable;
        next_irq_status = irq_status;
        next_readdata = readdata;
        next_answered = 1'b0;
        next_rx_flush = 1'b0;
        next_tx_flush = 1'b0;
        next_timeout_restart = 1'b0;
        if ((i_read || i_write) && !answered)
        begin
            next_answered = 1'b1;
        end
        if (wr_access)
        begin
            unique case (i_address)
                sfq_pkg::ADDR_CTRL_SET:
                begin
                    // Ones set, zeros leave bits as they are.
                    if (i_writedata[sfq_pkg::BIT_RX_LEVEL_EN] && wmask[0])
                    begin
                        next_ctrl.rx_level_irq_enable = 1'b1;
                    end
                    if (i_writedata[sfq_pkg::BIT_TX_LEVEL_EN] && wmask[0])
                    begin
                        next_ctrl.tx_level_irq_enable = 1'b1;
                    end
                    if (i_writedata[sfq_pkg::BIT_RX_TIMEOUT_EN] && wmask[0])
                    begin
                        next_ctrl.rx_timeout_irq_enable = 1'b1;
                        next_timeout_restart = 1'b1;
                    end
                    next_rx_flush = i_writedata[sfq_pkg::BIT_RX_FLUSH] && wmask[8];
                    next_tx_flush = i_writedata[sfq_pkg::BIT_TX_FLUSH] && wmask[8];
                end
                sfq_pkg::ADDR_CTRL_CLEAR:
                begin
                    // Only ones act; zero bits keep enables and flushes.
                    if (i_writedata[sfq_pkg::BIT_RX_LEVEL_EN] && wmask[0])
                    begin
                        next_ctrl.rx_level_irq_enable = 1'b0;
                    end
                    if (i_writedata[sfq_pkg::BIT_TX_LEVEL_EN] && wmask[0])
                    begin
                        next_ctrl.tx_level_irq_enable = 1'b0;
                    end
                    if (i_writedata[sfq_pkg::BIT_RX_TIMEOUT_EN] && wmask[0])
                    begin
                        next_ctrl.rx_timeout_irq_enable = 1'b0;
                    end
                end
                sfq_pkg::ADDR_IRQ_ENABLE:
                begin
                    next_irq_enable = (irq_enable & ~wmask[sfq_pkg::EV_WIDTH-1:0]) |
                                      (i_writedata[sfq_pkg::EV_WIDTH-1:0] &
                                       wmask[sfq_pkg::EV_WIDTH-1:0]);
                end
                sfq_pkg::ADDR_IRQ_CLEAR:
                begin
                    next_irq_status = irq_status & ~(i_writedata[sfq_pkg::EV_WIDTH-1:0] &
                                                     wmask[sfq_pkg::EV_WIDTH-1:0]);
                end
                sfq_pkg::ADDR_QUEUE_CFG:
                begin
                    if (wmask[0])
                    begin
                        next_rx_threshold = i_writedata[7:0];
                    end
                end
                default:
                begin
                    next_ctrl = ctrl;
                end
            endcase
        end
        if (rd_access)
        begin
            unique case (i_address)
                sfq_pkg::ADDR_CTRL_SET:
                begin
                    next_readdata = '0;
                    next_readdata[sfq_pkg::BIT_RX_LEVEL_EN] = ctrl.rx_level_irq_enable;
                    next_readdata[sfq_pkg::BIT_TX_LEVEL_EN] = ctrl.tx_level_irq_enable;
                    next_readdata[sfq_pkg::BIT_RX_TIMEOUT_EN] = ctrl.rx_timeout_irq_enable;
                end
                sfq_pkg::ADDR_RX_DATA:
                begin
                    next_readdata = entry_word(rx_head, 1'b0);
                end
                sfq_pkg::ADDR_RX_DATA_STATUS:
                begin
                    next_readdata = entry_word(rx_head, 1'b1);
                end
                sfq_pkg::ADDR_IRQ_STATUS:
                begin
                    next_readdata = {{(32 - sfq_pkg::EV_WIDTH){1'b0}}, irq_status};
                end
                sfq_pkg::ADDR_IRQ_ENABLE:
                begin
                    next_readdata = {{(32 - sfq_pkg::EV_WIDTH){1'b0}}, irq_enable};
                end
                sfq_pkg::ADDR_QUEUE_CFG:
                begin
                    next_readdata = {24'h000000, rx_threshold};
                end
                sfq_pkg::ADDR_QUEUE_LEVEL:
                begin
                    next_readdata = {{(32 - sfq_pkg::RX_CNT_W){1'b0}}, rx_count};
                end
                default:
                begin
                    // Unmapped and write-only addresses read as zero.
                    next_readdata = '0;
                end
            endcase
        end
        // Events are applied last so a set wins over a clear in the same cycle.
        if (ctrl.rx_level_irq_enable && rx_level_hit && !rx_level_prev)
        begin
            next_irq_status[sfq_pkg::EV_RX_LEVEL] = 1'b1;
        end
        if (ctrl.tx_level_irq_enable && tx_flush)
        begin
            // The transmit queue is empty after a flush, so its level is met.
            next_irq_status[sfq_pkg::EV_TX_LEVEL] = 1'b1;
        end
        if (timeout_expired)
        begin
            next_irq_status[sfq_pkg::EV_RX_TIMEOUT] = 1'b1;
        end
        if (overrun)
        begin
            next_irq_status[sfq_pkg::EV_RX_OVERRUN] = 1'b1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            ctrl <= '0;
            rx_threshold <= sfq_pkg::CFG_RESET;
            irq_status <= '0;
            irq_enable <= '0;
            readdata <= sfq_pkg::CTRL_RESET;
            answered <= 1'b0;
            rx_flush <= 1'b0;
            tx_flush <= 1'b0;
            timeout_restart <= 1'b0;
            rx_level_prev <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            rx_threshold <= next_rx_threshold;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            readdata <= next_readdata;
            answered <= next_answered;
            rx_flush <= next_rx_flush;
            tx_flush <= next_tx_flush;
            timeout_restart <= next_timeout_restart;
            rx_level_prev <= rx_level_hit;
        end
    end

    // ------------------------------------------------------------------
    // Receive queue and timeout
    // ------------------------------------------------------------------
    sfq_rx_queue u_rx_queue
    (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_push(i_rx_push),
        .i_push_data(i_rx_entry),
        .o_push_ready(o_rx_push_ready),
        .i_pop(rx_pop),
        .o_head(rx_head),
        .i_flush(rx_flush),
        .o_count(rx_count)
    );

    sfq_rx_timeout u_rx_timeout
    (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_enable(ctrl.rx_timeout_irq_enable),
        .i_restart(timeout_restart || i_rx_push),
        .i_not_empty(rx_count != '0),
        .o_expired(timeout_expired)
    );

endmodule

`default_nettype wire

// File: tb/sfq_uart_port_asserts.sv
// Port-level checks for the serial queue control and receive port.
// Assumes the bind below attaches it to every instance of the port.
`default_nettype none

module sfq_uart_port_asserts
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Bus
    input wire logic [15:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    // Receiver and events
    input wire logic i_rx_push,
    input wire sfq_pkg::sfq_rx_entry_s i_rx_entry,
    input wire logic o_rx_push_ready,
    input wire logic o_tx_queue_flush,
    input wire logic o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    // A write lands in the first cycle of the access, while waitrequest is still high.
    logic set_wr;
    assign set_wr = i_write && o_waitrequest && i_address == sfq_pkg::ADDR_CTRL_SET;
    logic bus_req;
    logic tx_flush_req;
    assign bus_req = i_read || i_write;
    assign tx_flush_req = set_wr && i_writedata[9];

    wait_state_a: assert property ($rose(bus_req) |-> o_waitrequest ##1 !o_waitrequest)
        else $error("access not answered after one wait state");
    tx_flush_a: assert property (set_wr && i_writedata[9] && i_byteenable[1] |=> o_tx_queue_flush ##1 !o_tx_queue_flush)
        else $error("transmit flush pulse missing or too long");
    flush_cause_a: assert property (o_tx_queue_flush |-> $past(tx_flush_req))
        else $error("transmit flush without a set write");
    clear_zero_a: assert property (i_write && i_address == sfq_pkg::ADDR_CTRL_CLEAR |=> !o_tx_queue_flush)
        else $error("clear write caused a transmit flush");
    ready_fall_a: assert property ($fell(o_rx_push_ready) |-> $past(i_rx_push))
        else $error("queue filled without a push");
    ready_rise_a: assert property ($rose(o_rx_push_ready) |-> $past(bus_req))
        else $error("queue drained without a bus access");
    data_hold_a: assert property ($changed(o_readdata) |-> $past(i_read))
        else $error("read data changed without a read");
    irq_reset_a: assert property ($rose(i_rst_n) |-> !o_irq)
        else $error("interrupt high out of reset");
    irq_mask_a: assert property (i_write && i_address == sfq_pkg::ADDR_IRQ_ENABLE && i_byteenable[0]
        && i_writedata[3:0] == 4'h0 |=> !o_irq)
        else $error("interrupt high with all enables cleared");
endmodule

bind sfq_uart_port sfq_uart_port_asserts SVA (.i_clock, .i_rst_n, .i_address, .i_read,
    .i_write, .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest, .i_rx_push,
    .i_rx_entry, .o_rx_push_ready, .o_tx_queue_flush, .o_irq);

`default_nettype wire

// File: tb/sfq_rx_source.sv
// Model of the serial receiver that pushes characters into the port.
// Assumes send is called from the bench; it starts on the next rising edge.
`default_nettype none

module sfq_rx_source
(
    // Clock
    input wire logic i_clock,
    // Push side
    output logic o_push,
    output sfq_pkg::sfq_rx_entry_s o_entry
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_push = 1'b0;
        o_entry = '0;
    end

    // Pushes n entries back to back; a real receiver never waits for room.
    task automatic send(input int n, input logic [8:0] base);
        @(posedge i_clock);
        for (int i = 0; i < n; i++)
        begin
            o_push <= 1'b1;
            o_entry <= {i[2:0], base + i[8:0]};
            @(posedge i_clock);
        end
        o_push <= 1'b0;
        o_entry <= ~o_entry;
    endtask
endmodule

`default_nettype wire

// File: tb/test_serial_fifo_control_rx_port.sv
// Self-checking bench for the serial queue control and receive port.
// Assumes the receiver model and the bound checker are compiled alongside.
`default_nettype none

module test_serial_fifo_control_rx_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0;
    logic i_rst_n, i_read, i_write, i_rx_push, o_rx_push_ready, o_tx_queue_flush, o_irq;
    logic o_waitrequest;
    logic [15:0] i_address;
    logic [31:0] i_writedata, o_readdata;
    logic [3:0] i_byteenable;
    sfq_pkg::sfq_rx_entry_s i_rx_entry;
    int fails = 0;
    int total_checks = 0;
    int flush_seen = 0;

    sfq_uart_port DUT (.i_clock, .i_rst_n, .i_address, .i_read, .i_write, .i_writedata,
        .i_byteenable, .o_readdata, .o_waitrequest, .i_rx_push, .i_rx_entry,
        .o_rx_push_ready, .o_tx_queue_flush, .o_irq);
    sfq_rx_source SRC (.i_clock, .o_push(i_rx_push), .o_entry(i_rx_entry));

    always #5 i_clock = ~i_clock;
    always @(posedge i_clock)
        if (o_tx_queue_flush === 1'b1)
            flush_seen <= flush_seen + 1;

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Outputs are looked at on the falling edge, away from the updates of the rising edge.
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        logic w;
        int n;
        n = 0;
        @(posedge i_clock);
        i_address <= a;
        i_writedata <= wd;
        i_write <= wr;
        i_read <= !wr;
        do
        begin
            @(negedge i_clock);
            w = o_waitrequest;
            rd = o_readdata;
            @(posedge i_clock);
            n++;
        end
        while (w !== 1'b0 && n < 16);
        i_read <= 1'b0;
        i_write <= 1'b0;
        if (w !== 1'b0)
        begin
            fails++;
            final_report();
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        check(d & m, e);
    endtask

    task automatic pin_chk(input logic exp);
        @(negedge i_clock);
        check({31'h0, o_irq}, {31'h0, exp});
    endtask

    function automatic logic [31:0] exp_entry(input int i, input logic [8:0] b, input logic st);
        logic [8:0] c;
        c = b + 9'(i);
        return st ? {16'h0, 3'(i), 4'h0, c} : {23'h0, c};
    endfunction

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        rd_chk(sfq_pkg::ADDR_CTRL_SET, 32'h0, 32'h313);
        rd_chk(sfq_pkg::ADDR_CTRL_CLEAR, 32'h0, 32'hFFFFFFFF);
        rd_chk(16'h1100, 32'h0, 32'hFFFFFFFF);
        pin_chk(1'b0);
        $display("test reset done");
    endtask

    task automatic t_enables();
        int f;
        wr(sfq_pkg::ADDR_CTRL_SET, 32'h13);
        rd_chk(sfq_pkg::ADDR_CTRL_SET, 32'h13, 32'h313);
        wr(sfq_pkg::ADDR_CTRL_CLEAR, 32'h0);
        rd_chk(sfq_pkg::ADDR_CTRL_SET, 32'h13, 32'h313);
        wr(sfq_pkg::ADDR_CTRL_CLEAR, 32'h12);
        rd_chk(sfq_pkg::ADDR_CTRL_SET, 32'h1, 32'h313);
        wr(sfq_pkg::ADDR_CTRL_CLEAR, 32'h301);
        rd_chk(sfq_pkg::ADDR_CTRL_SET, 32'h0, 32'h313);
        f = flush_seen;
        wr(sfq_pkg::ADDR_CTRL_SET, 32'h202);
        @(negedge i_clock);
        check(32'(flush_seen - f), 32'h1);
        $display("test enables done");
    endtask

    task automatic t_data();
        wr(sfq_pkg::ADDR_CTRL_SET, 32'h1);
        SRC.send(9, 9'h1F8);
        @(negedge i_clock);
        check({31'h0, o_rx_push_ready}, 32'h0);
        rd_chk(sfq_pkg::ADDR_QUEUE_LEVEL, 32'h8, 32'hFF);
        rd_chk(sfq_pkg::ADDR_IRQ_STATUS, 32'hB, 32'hB);
        for (int i = 0; i < 8; i++)
        begin
            if (i % 2 == 1)
                rd_chk(sfq_pkg::ADDR_RX_DATA_STATUS, exp_entry(i, 9'h1F8, 1'b1), 32'hE1FF);
            else
                rd_chk(sfq_pkg::ADDR_RX_DATA, exp_entry(i, 9'h1F8, 1'b0), 32'h1FF);
        end
        rd_chk(sfq_pkg::ADDR_QUEUE_LEVEL, 32'h0, 32'hFF);
        rd_chk(sfq_pkg::ADDR_RX_DATA_STATUS, 32'h0, 32'hFFFFFFFF);
        SRC.send(3, 9'h055);
        wr(sfq_pkg::ADDR_CTRL_SET, 32'h100);
        rd_chk(sfq_pkg::ADDR_QUEUE_LEVEL, 32'h0, 32'hFF);
        rd_chk(sfq_pkg::ADDR_RX_DATA, 32'h0, 32'hFFFFFFFF);
        $display("test data done");
    endtask

    task automatic t_timeout();
        int n;
        wr(sfq_pkg::ADDR_IRQ_CLEAR, 32'hF);
        wr(sfq_pkg::ADDR_IRQ_ENABLE, 32'h4);
        SRC.send(1, 9'h0AA);
        repeat (1100) @(posedge i_clock);
        pin_chk(1'b0);
        wr(sfq_pkg::ADDR_CTRL_SET, 32'h10);
        n = 0;
        while (o_irq !== 1'b1 && n < 1200)
        begin
            @(negedge i_clock);
            n++;
        end
        check(32'(n >= 900 && n <= 1100), 32'h1);
        if (n >= 1200)
            final_report();
        wr(sfq_pkg::ADDR_IRQ_CLEAR, 32'h4);
        pin_chk(1'b0);
        repeat (600) @(posedge i_clock);
        wr(sfq_pkg::ADDR_CTRL_SET, 32'h10);
        repeat (600) @(posedge i_clock);
        pin_chk(1'b0);
        repeat (500) @(posedge i_clock);
        pin_chk(1'b1);
        wr(sfq_pkg::ADDR_IRQ_ENABLE, 32'h0);
        pin_chk(1'b0);
        wr(sfq_pkg::ADDR_CTRL_CLEAR, 32'h13);
        rd_chk(sfq_pkg::ADDR_CTRL_SET, 32'h0, 32'h313);
        $display("test timeout done");
    endtask

    initial
    begin
        i_rst_n = 1'b0;
        i_address = 16'h0;
        i_read = 1'b0;
        i_write = 1'b0;
        i_writedata = 32'h0;
        i_byteenable = 4'hF;
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
        t_reset();
        t_enables();
        t_data();
        t_timeout();
        final_report();
    end
endmodule

`default_nettype wire
